// ### verilog/rtcirq_top.sv
// Alarm comparators, periodic interrupt and slow clock output of a real-time clock
// Assumes time counters, oscillator and register port are outside and synchronous to clock
// Notes on behaviour
// RULE1: Alarm channel works only while enabled.
// RULE2: Flag write 1 ignored, 0 clears.
// RULE3: Flag reads show pending alarm match.
// RULE4: Clearing flag keeps enable; channel stays armed.
// RULE5: Weekly: day, hour, minute; daily: hour, minute.
// RULE6: Host disables alarm while rewriting alarm time.
// RULE7: Enabling on a live match does not fire.
// RULE8: Select 000 off high, 001 fixed low.
// RULE9: Select 010/011 give 2 Hz/1 Hz square.
// RULE10: Select 1xx: second, minute, hour, month events.
// RULE11: Level mode stays low until flag cleared.
// RULE12: Pulse falling edge leads increment by 92 us.
// RULE13: Level falling edge meets second increment.
// RULE14: Seconds write resets divider, pulse goes low.
// RULE15: Adjustment perturbs cycle by at most 3.784 ms.
// RULE16: Clock out when gate high, not both disabled.
// RULE17: Disable bits in both registers, default zero.
// RULE18: Irq A ORs daily and periodic; B weekly.
// RULE19: Power-on flag clears enables, flags, select, disables.
// RULE20: Clock out changes only at clock boundaries.
// RULE21: Interrupt pins are open drain.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module rtcirq_top
    import rtcirq_pkg::*;
#(
    parameter int LEAD = LEAD_TICKS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regReadData,
    input wire logic slowClockIn,
    input wire logic clockoutGatePin,
    input wire rtcirq_time_s currentTime,
    input wire logic secondsWrite,
    input wire logic adjustStrobe,
    input wire logic signed [ADJ_W-1:0] adjustTicks,
    input wire logic poweronEvent,
    output logic secondIncrement,
    output logic irqOutAOut,
    output logic irqOutAOe,
    output logic irqOutBOut,
    output logic irqOutBOe,
    output logic slowClockOut
);
    if (LEAD < 1 || LEAD >= 2 ** (TICK_W - 2)) begin : g_check
        $error("rtcirq_top: unsupported LEAD");
    end

    // Control and status
    logic weeklyEnable_r;
    logic dailyEnable_r;
    logic clockoutDisable1_r;
    logic clockoutDisable2_r;
    rtcirq_psel_e periodicSelect_r;
    logic weeklyFlag_r;
    logic dailyFlag_r;
    logic periodicFlag_r;
    logic poweronFlag_r;

    // Alarm times
    logic [MIN_W-1:0] weeklyMinute_r;
    logic [HOUR_W-1:0] weeklyHour_r;
    logic [WEEK_DAYS-1:0] weeklyDays_r;
    logic [MIN_W-1:0] dailyMinute_r;
    logic [HOUR_W-1:0] dailyHour_r;

    // Internal events
    logic oscPrev_r;
    logic oscTick;
    logic secondTick;
    logic tickSeen_r;
    logic [TICK_W-1:0] subSecond;
    logic [TICK_W-1:0] leadPhase;
    logic weeklyMatch;
    logic dailyMatch;
    logic weeklyMatchPrev_r;
    logic dailyMatchPrev_r;
    logic weeklySet;
    logic dailySet;
    logic levelHit;
    logic periodicSet;
    logic periodicLow;
    logic writeCtrl1;
    logic writeCtrl2;
    logic clearEvent;
    logic irqAOe_r;
    logic irqBOe_r;
    logic [DATA_W-1:0] readData_r;

    function automatic logic timeMatch(
        input logic [MIN_W-1:0] almMinute,
        input logic [HOUR_W-1:0] almHour,
        input rtcirq_time_s now
    );
        return (almMinute == now.minute) && (almHour == now.hour);
    endfunction

    // Hardware set wins over software clear
    function automatic logic flagNext(input logic cur, input logic set, input logic clr);
        return set || (cur && !clr);
    endfunction

    assign writeCtrl1 = regWrite && (regAddr == ADDR_CTRL1);
    assign writeCtrl2 = regWrite && (regAddr == ADDR_CTRL2);
    assign clearEvent = reset || poweronEvent;

    // Oscillator edge and second divider
    always_ff @(posedge clock) begin
        if (reset) begin
            oscPrev_r <= 1'b0;
        end else begin
            oscPrev_r <= slowClockIn;
        end
    end

    assign oscTick = slowClockIn && !oscPrev_r;

    rtcirq_divider #(
        .DIV_W(TICK_W),
        .LEAD(LEAD)
    ) u_divider (
        .clock(clock),
        .reset(reset),
        .oscTick(oscTick),
        .secondsWrite(secondsWrite),
        .adjustStrobe(adjustStrobe),
        .adjustTicks(adjustTicks),
        .subSecond(subSecond),
        .secondTick(secondTick)
    );

    assign secondIncrement = secondTick;

    // Control register one
    always_ff @(posedge clock) begin
        if (clearEvent) begin
            weeklyEnable_r <= 1'b0; // [RULE19]
            dailyEnable_r <= 1'b0;
            clockoutDisable2_r <= 1'b0; // [RULE17]
            periodicSelect_r <= PSEL_OFF; // [RULE8]
        end else if (writeCtrl1) begin
            weeklyEnable_r <= regWriteData[BIT_WEEKLY_EN]; // [RULE1]
            dailyEnable_r <= regWriteData[BIT_DAILY_EN];
            clockoutDisable2_r <= regWriteData[BIT_CLK_DIS2];
            periodicSelect_r <= rtcirq_psel_e'(regWriteData[BIT_PSEL_HI:BIT_PSEL_LO]);
        end
    end

    // Control register two: disable bit and power-on flag
    always_ff @(posedge clock) begin
        if (clearEvent) begin
            clockoutDisable1_r <= 1'b0; // [RULE17]
            poweronFlag_r <= 1'b1;
        end else if (writeCtrl2) begin
            clockoutDisable1_r <= regWriteData[BIT_CLK_DIS1];
            poweronFlag_r <= poweronFlag_r && regWriteData[BIT_PON];
        end
    end

    // Alarm time registers
    always_ff @(posedge clock) begin
        if (reset) begin
            weeklyMinute_r <= '0;
            weeklyHour_r <= '0;
            weeklyDays_r <= '0;
            dailyMinute_r <= '0;
            dailyHour_r <= '0;
        end else if (regWrite) begin
            case (regAddr)
                ADDR_ALW_MIN: weeklyMinute_r <= regWriteData[MIN_W-1:0];
                ADDR_ALW_HOUR: weeklyHour_r <= regWriteData[HOUR_W-1:0];
                ADDR_ALW_DAYS: weeklyDays_r <= regWriteData[WEEK_DAYS-1:0];
                ADDR_ALD_MIN: dailyMinute_r <= regWriteData[MIN_W-1:0];
                ADDR_ALD_HOUR: dailyHour_r <= regWriteData[HOUR_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Alarm comparators
    assign weeklyMatch = (currentTime.weekday < WDAY_W'(WEEK_DAYS))
        && weeklyDays_r[currentTime.weekday]
        && timeMatch(weeklyMinute_r, weeklyHour_r, currentTime); // [RULE5]
    assign dailyMatch = timeMatch(dailyMinute_r, dailyHour_r, currentTime); // [RULE5]

    // Match history runs regardless of enable
    always_ff @(posedge clock) begin
        if (reset) begin
            weeklyMatchPrev_r <= 1'b0;
            dailyMatchPrev_r <= 1'b0;
        end else begin
            weeklyMatchPrev_r <= weeklyMatch;
            dailyMatchPrev_r <= dailyMatch;
        end
    end

    // Only a fresh match fires
    assign weeklySet = weeklyEnable_r && weeklyMatch && !weeklyMatchPrev_r; // [RULE7] [RULE1] [RULE4]
    assign dailySet = dailyEnable_r && dailyMatch && !dailyMatchPrev_r; // [RULE7] [RULE1] [RULE4]

    // Level mode event, checked once counters hold the new time
    always_ff @(posedge clock) begin
        if (reset) begin
            tickSeen_r <= 1'b0;
        end else begin
            tickSeen_r <= secondTick;
        end
    end

    always_comb begin
        levelHit = 1'b0;
        case (periodicSelect_r)
            PSEL_LVL_SECOND: levelHit = 1'b1;
            PSEL_LVL_MINUTE: levelHit = currentTime.second == SEC_ZERO;
            PSEL_LVL_HOUR: levelHit = (currentTime.second == SEC_ZERO)
                && (currentTime.minute == MIN_ZERO);
            PSEL_LVL_MONTH: levelHit = (currentTime.second == SEC_ZERO)
                && (currentTime.minute == MIN_ZERO)
                && (currentTime.hour == HOUR_ZERO)
                && (currentTime.monthDay == FIRST_DAY);
            default: levelHit = 1'b0;
        endcase
    end

    assign periodicSet = tickSeen_r && levelHit; // [RULE10] [RULE13]

    // Interrupt flags
    always_ff @(posedge clock) begin
        if (clearEvent) begin
            weeklyFlag_r <= 1'b0; // [RULE19]
            dailyFlag_r <= 1'b0;
            periodicFlag_r <= 1'b0;
        end else begin
            weeklyFlag_r <= flagNext(weeklyFlag_r, weeklySet,
                writeCtrl2 && !regWriteData[BIT_WEEKLY_FLAG]); // [RULE2]
            dailyFlag_r <= flagNext(dailyFlag_r, dailySet,
                writeCtrl2 && !regWriteData[BIT_DAILY_FLAG]); // [RULE2]
            periodicFlag_r <= flagNext(periodicFlag_r, periodicSet,
                writeCtrl2 && !regWriteData[BIT_PFLAG]); // [RULE11]
        end
    end

    // Pulse phase shifted so the fall leads the increment
    assign leadPhase = subSecond + TICK_W'(LEAD); // [RULE12]

    always_comb begin
        periodicLow = 1'b0;
        case (periodicSelect_r)
            PSEL_OFF: periodicLow = 1'b0; // [RULE8]
            PSEL_FIXED_LOW: periodicLow = 1'b1; // [RULE8]
            PSEL_PULSE_2HZ: periodicLow = !leadPhase[TICK_W-2]; // [RULE9]
            PSEL_PULSE_1HZ: periodicLow = !leadPhase[TICK_W-1]; // [RULE9]
            PSEL_LVL_SECOND,
            PSEL_LVL_MINUTE,
            PSEL_LVL_HOUR,
            PSEL_LVL_MONTH: periodicLow = periodicFlag_r; // [RULE11]
            default: periodicLow = 1'b0;
        endcase
    end

    // Open-drain interrupt drivers
    always_ff @(posedge clock) begin
        if (reset) begin
            irqAOe_r <= 1'b0;
            irqBOe_r <= 1'b0;
        end else begin
            irqAOe_r <= dailyFlag_r || periodicLow; // [RULE18]
            irqBOe_r <= weeklyFlag_r; // [RULE18]
        end
    end

    assign irqOutAOut = 1'b0; // [RULE21]
    assign irqOutBOut = 1'b0; // [RULE21]
    assign irqOutAOe = irqAOe_r;
    assign irqOutBOe = irqBOe_r;

    // Register read, data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            readData_r <= '0;
        end else if (regRead) begin
            readData_r <= '0;
            case (regAddr)
                ADDR_ALW_MIN: readData_r[MIN_W-1:0] <= weeklyMinute_r;
                ADDR_ALW_HOUR: readData_r[HOUR_W-1:0] <= weeklyHour_r;
                ADDR_ALW_DAYS: readData_r[WEEK_DAYS-1:0] <= weeklyDays_r;
                ADDR_ALD_MIN: readData_r[MIN_W-1:0] <= dailyMinute_r;
                ADDR_ALD_HOUR: readData_r[HOUR_W-1:0] <= dailyHour_r;
                ADDR_CTRL1: begin
                    readData_r[BIT_WEEKLY_EN] <= weeklyEnable_r;
                    readData_r[BIT_DAILY_EN] <= dailyEnable_r;
                    readData_r[BIT_CLK_DIS2] <= clockoutDisable2_r;
                    readData_r[BIT_PSEL_HI:BIT_PSEL_LO] <= periodicSelect_r;
                end
                ADDR_CTRL2: begin
                    readData_r[BIT_PON] <= poweronFlag_r;
                    readData_r[BIT_CLK_DIS1] <= clockoutDisable1_r;
                    readData_r[BIT_PFLAG] <= periodicFlag_r;
                    readData_r[BIT_WEEKLY_FLAG] <= weeklyFlag_r; // [RULE3]
                    readData_r[BIT_DAILY_FLAG] <= dailyFlag_r; // [RULE3]
                end
                default: begin
                end
            endcase
        end
    end

    assign regReadData = readData_r;

    // Gated slow clock output
    rtcirq_clkout u_clkout (
        .clock(clock),
        .reset(reset),
        .slowClockIn(slowClockIn),
        .enableReq(clockoutGatePin && !(clockoutDisable1_r && clockoutDisable2_r)), // [RULE16]
        .slowClockOut(slowClockOut)
    );
endmodule

// ### common/rtcirq_pkg.sv
// Shared constants and types of the alarm, periodic interrupt and clock-out block
// Assumes one system clock; oscillator and time counters are synchronous inputs
package rtcirq_pkg;
    // Oscillator and sub-second divider
    localparam int OSC_HZ = 32768;
    localparam int TICK_W = $clog2(OSC_HZ);
    // Pulse-mode lead of the falling edge before the second increment
    localparam int LEAD_US = 92;
    localparam int LEAD_TICKS = (LEAD_US * OSC_HZ) / 1000000;
    // Largest cycle change from oscillation adjustment
    localparam int ADJ_MAX_US = 3784;
    localparam int ADJ_MAX_TICKS = (ADJ_MAX_US * OSC_HZ) / 1000000;
    localparam int ADJ_W = 8;
    localparam logic signed [ADJ_W-1:0] ADJ_LIMIT = ADJ_W'(ADJ_MAX_TICKS);

    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_ALW_MIN = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_ALW_HOUR = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_ALW_DAYS = 4'hA;
    localparam logic [ADDR_W-1:0] ADDR_ALD_MIN = 4'hB;
    localparam logic [ADDR_W-1:0] ADDR_ALD_HOUR = 4'hC;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 4'hE;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 4'hF;

    // Control register one fields
    localparam int BIT_WEEKLY_EN = 7;
    localparam int BIT_DAILY_EN = 6;
    localparam int BIT_CLK_DIS2 = 4;
    localparam int BIT_PSEL_HI = 2;
    localparam int BIT_PSEL_LO = 0;
    // Control register two fields
    localparam int BIT_PON = 4;
    localparam int BIT_CLK_DIS1 = 3;
    localparam int BIT_PFLAG = 2;
    localparam int BIT_WEEKLY_FLAG = 1;
    localparam int BIT_DAILY_FLAG = 0;

    // Time field widths and codes
    localparam int MIN_W = 7;
    localparam int HOUR_W = 6;
    localparam int DAY_W = 6;
    localparam int WDAY_W = 3;
    localparam int WEEK_DAYS = 7;
    localparam logic [MIN_W-1:0] SEC_ZERO = 7'h00;
    localparam logic [MIN_W-1:0] MIN_ZERO = 7'h00;
    localparam logic [HOUR_W-1:0] HOUR_ZERO = 6'h00;
    localparam logic [DAY_W-1:0] FIRST_DAY = 6'h01;

    typedef struct packed {
        logic [DAY_W-1:0] monthDay;
        logic [WDAY_W-1:0] weekday;
        logic [HOUR_W-1:0] hour;
        logic [MIN_W-1:0] minute;
        logic [MIN_W-1:0] second;
    } rtcirq_time_s;

    typedef enum logic [2:0] {
        PSEL_OFF = 3'h0,
        PSEL_FIXED_LOW = 3'h1,
        PSEL_PULSE_2HZ = 3'h2,
        PSEL_PULSE_1HZ = 3'h3,
        PSEL_LVL_SECOND = 3'h4,
        PSEL_LVL_MINUTE = 3'h5,
        PSEL_LVL_HOUR = 3'h6,
        PSEL_LVL_MONTH = 3'h7
    } rtcirq_psel_e;
endpackage

// ### verilog/rtcirq_divider.sv
// Sub-second divider: oscillator ticks to second increment
// Assumes oscTick is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
module rtcirq_divider
    import rtcirq_pkg::*;
#(
    parameter int DIV_W = TICK_W,
    parameter int LEAD = LEAD_TICKS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic oscTick,
    input wire logic secondsWrite,
    input wire logic adjustStrobe,
    input wire logic signed [ADJ_W-1:0] adjustTicks,
    output logic [DIV_W-1:0] subSecond,
    output logic secondTick
);
    if (DIV_W < 3 || LEAD < 1 || LEAD >= 2 ** (DIV_W - 2)) begin : g_check
        $error("rtcirq_divider: unsupported DIV_W or LEAD");
    end

    logic [DIV_W-1:0] div_r;
    logic signed [ADJ_W-1:0] pend_r;
    logic secondTick_r;
    logic [1:0] step;
    logic [DIV_W:0] stepSum;

    function automatic logic signed [ADJ_W-1:0] clampAdj(input logic signed [ADJ_W-1:0] v);
        if (v > ADJ_LIMIT) begin
            return ADJ_LIMIT;
        end else if (v < -ADJ_LIMIT) begin
            return -ADJ_LIMIT;
        end
        return v;
    endfunction

    // Held or doubled ticks stretch or shrink one cycle
    always_comb begin
        step = 2'h1;
        if (pend_r > 0) begin
            step = 2'h0;
        end else if (pend_r < 0) begin
            step = 2'h2;
        end
        stepSum = {1'b0, div_r} + {{(DIV_W-1){1'b0}}, step};
    end

    always_ff @(posedge clock) begin
        if (reset || secondsWrite) begin
            div_r <= '0; // [RULE14]
        end else if (oscTick) begin
            div_r <= stepSum[DIV_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pend_r <= '0;
        end else if (adjustStrobe) begin
            pend_r <= clampAdj(adjustTicks); // [RULE15]
        end else if (oscTick && pend_r > 0) begin
            pend_r <= pend_r - ADJ_W'(1);
        end else if (oscTick && pend_r < 0) begin
            pend_r <= pend_r + ADJ_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            secondTick_r <= 1'b0;
        end else begin
            secondTick_r <= oscTick && stepSum[DIV_W] && !secondsWrite;
        end
    end

    assign subSecond = div_r;
    assign secondTick = secondTick_r;
endmodule

// ### verilog/rtcirq_clkout.sv
// Gated slow clock output without runt pulses
// Assumes slowClockIn is the oscillator level, synchronous to clock
`timescale 1ns/1ps
module rtcirq_clkout (
    input wire logic clock,
    input wire logic reset,
    input wire logic slowClockIn,
    input wire logic enableReq,
    output logic slowClockOut
);
    logic enable_r;
    logic out_r;

    // Enable moves only while the clock is low
    always_ff @(posedge clock) begin
        if (reset) begin
            enable_r <= 1'b0;
        end else if (!slowClockIn) begin
            enable_r <= enableReq; // [RULE20]
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            out_r <= 1'b0;
        end else begin
            out_r <= slowClockIn && enable_r; // [RULE16]
        end
    end

    assign slowClockOut = out_r;
endmodule

// ### testbench/rtcirq_host_model.sv
// Host side: pull-ups on both interrupt lines, rising-edge count of slow clock
// Assumes open-drain data and enable ports of rtcirq_top
`timescale 1ns/1ps
module rtcirq_host_model (
    input wire logic clock,
    input wire logic irqOutAOut,
    input wire logic irqOutAOe,
    input wire logic irqOutBOut,
    input wire logic irqOutBOe,
    input wire logic slowClockOut,
    output logic irqALine,
    output logic irqBLine,
    output int clkEdges
);
    logic lastClk_r;
    // Released line floats to pull-up level
    assign irqALine = irqOutAOe ? irqOutAOut : 1'h1;
    assign irqBLine = irqOutBOe ? irqOutBOut : 1'h1;
    always_ff @(posedge clock) begin
        lastClk_r <= slowClockOut;
        if (slowClockOut && !lastClk_r) begin
            clkEdges <= clkEdges + 1;
        end
    end
endmodule

// ### testbench/rtcirq_top_monitor.sv
// Checker of interrupt and clock-out timing at the top ports
// Assumes bound to rtcirq_top, one clock domain
`timescale 1ns/1ps
module rtcirq_top_monitor
    import rtcirq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic slowClockIn,
    input wire logic clockoutGatePin,
    input wire logic secondsWrite,
    input wire logic poweronEvent,
    input wire logic secondIncrement,
    input wire logic irqOutAOut,
    input wire logic irqOutAOe,
    input wire logic irqOutBOut,
    input wire logic irqOutBOe,
    input wire logic slowClockOut
);
    logic [2:0] selShadow_r;
    // Copy of the periodic select field
    always_ff @(posedge clock) begin
        if (reset || poweronEvent) begin
            selShadow_r <= 3'h0;
        end else if (regWrite && regAddr == ADDR_CTRL1) begin
            selShadow_r <= regWriteData[2:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_irq_open_drain: assert property (irqOutAOut == 1'h0 && irqOutBOut == 1'h0)
        else $error("Interrupt data not low");
    a_fixed_low_hold: assert property (selShadow_r == 3'h1 && $stable(selShadow_r) |-> irqOutAOe)
        else $error("Fixed low select not driving");
    a_pulse_restart_low: assert property (secondsWrite && selShadow_r[2:1] == 2'h1 |-> ##2 irqOutAOe)
        else $error("Seconds write did not pull pulse low");
    a_level_fall_inc: assert property (secondIncrement && selShadow_r == 3'h4 |-> ##3 irqOutAOe)
        else $error("Level event missed second increment");
    a_level_stays_low: assert property (irqOutAOe && selShadow_r[2] && !regWrite && !$past(regWrite)
        && !$past(poweronEvent) |=> irqOutAOe)
        else $error("Level output released without clear");
    a_weekly_clear_drop: assert property (regWrite && regAddr == ADDR_CTRL2
        && !regWriteData[BIT_WEEKLY_FLAG] |-> ##2 !irqOutBOe)
        else $error("Weekly output not released");
    a_clk_rise_src: assert property ($rose(slowClockOut) |-> $past(slowClockIn))
        else $error("Slow clock rose without source");
    a_clk_gate_off: assert property ((!clockoutGatePin && !slowClockIn) ##1 !clockoutGatePin[*2]
        |-> !slowClockOut)
        else $error("Slow clock not held low");
endmodule
bind rtcirq_top rtcirq_top_monitor u_rtcirq_top_monitor (.clock, .reset, .regAddr, .regWriteData, .regWrite,
    .slowClockIn, .clockoutGatePin, .secondsWrite, .poweronEvent, .secondIncrement, .irqOutAOut, .irqOutAOe,
    .irqOutBOut, .irqOutBOe, .slowClockOut);

// ### testbench/tb_rtcirq_top.sv
// Self-checking bench of alarms, periodic interrupt and slow clock output
// Assumes package, design, checker and host model compiled first
`timescale 1ns/1ps
module tb_rtcirq_top
    import rtcirq_pkg::*;
;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWriteData = '0;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [DATA_W-1:0] regReadData;
    logic slowClockIn = 1'h0;
    logic clockoutGatePin = 1'h1;
    rtcirq_time_s currentTime = '0;
    logic secondsWrite = 1'h0;
    logic adjustStrobe = 1'h0;
    logic signed [ADJ_W-1:0] adjustTicks = '0;
    logic poweronEvent = 1'h0;
    logic secondIncrement, irqOutAOut, irqOutAOe, irqOutBOut, irqOutBOe, slowClockOut, irqALine, irqBLine;
    int clkEdges;
    int failCount = 0;
    int nCompared = 0;

    always #4 clock = ~clock;
    // Fast oscillator so a second fits the run
    always @(posedge clock) slowClockIn <= ~slowClockIn;

    rtcirq_top u_rtcirq_top (.clock, .reset, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
        .slowClockIn, .clockoutGatePin, .currentTime, .secondsWrite, .adjustStrobe, .adjustTicks, .poweronEvent,
        .secondIncrement, .irqOutAOut, .irqOutAOe, .irqOutBOut, .irqOutBOe, .slowClockOut);
    rtcirq_host_model u_rtcirq_host_model (.clock, .irqOutAOut, .irqOutAOe, .irqOutBOut, .irqOutBOe,
        .slowClockOut, .irqALine, .irqBLine, .clkEdges);

    task automatic results();
        if (failCount == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failCount++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'h1;
        @(posedge clock);
        regWrite <= 1'h0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clock);
        regRead <= 1'h0;
        #1;
        check(regReadData, exp);
    endtask

    task automatic st(input logic [2:0] wd, input logic [5:0] h, input logic [6:0] m);
        @(posedge clock);
        currentTime <= '{monthDay: 6'h01, weekday: wd, hour: h, minute: m, second: 7'h00};
        idle(3);
    endtask

    task automatic pulseSec();
        @(posedge clock);
        secondsWrite <= 1'h1;
        @(posedge clock);
        secondsWrite <= 1'h0;
        idle(2);
    endtask

    task automatic waitA(input logic lvl, output int n);
        n = 0;
        while (irqALine !== lvl) begin
            idle(1);
            n++;
            if (n > 40000) begin
                check(irqALine, lvl);
                results();
            end
        end
    endtask

    task automatic edges(input int exp);
        int c0;
        idle(4);
        c0 = clkEdges;
        idle(16);
        check(clkEdges - c0, exp);
    endtask

    task automatic tRegs();
        rd(ADDR_CTRL1, 8'h00);
        rd(ADDR_CTRL2, 8'h10);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CTRL1, 8'(c));
            rd(ADDR_CTRL1, 8'(c));
            if (c < 2) begin
                check(irqALine, c == 0);
            end
        end
        wr(4'hD, 8'hFF);
        rd(4'hD, 8'h00);
        wr(ADDR_CTRL1, 8'h00);
    endtask

    task automatic tDaily();
        wr(ADDR_ALD_MIN, 8'h30);
        wr(ADDR_ALD_HOUR, 8'h12);
        st(3'h2, 6'h12, 7'h30);
        check(irqALine, 1'h1);
        st(3'h2, 6'h12, 7'h31);
        wr(ADDR_CTRL1, 8'h40);
        st(3'h2, 6'h12, 7'h30);
        check(irqALine, 1'h0);
        check(irqBLine, 1'h1);
        rd(ADDR_CTRL2, 8'h11);
        wr(ADDR_CTRL2, 8'h17);
        rd(ADDR_CTRL2, 8'h11);
        wr(ADDR_CTRL2, 8'h10);
        idle(2);
        check(irqALine, 1'h1);
        rd(ADDR_CTRL1, 8'h40);
        st(3'h2, 6'h12, 7'h31);
        st(3'h6, 6'h12, 7'h30);
        check(irqALine, 1'h0);
        wr(ADDR_CTRL2, 8'h10);
        wr(ADDR_CTRL1, 8'h00);
        wr(ADDR_CTRL1, 8'h40);
        idle(4);
        check(irqALine, 1'h1);
        st(3'h6, 6'h13, 7'h30);
        check(irqALine, 1'h1);
        st(3'h6, 6'h12, 7'h30);
        check(irqALine, 1'h0);
        wr(ADDR_CTRL2, 8'h10);
        wr(ADDR_CTRL1, 8'h00);
        st(3'h6, 6'h12, 7'h31);
        st(3'h6, 6'h12, 7'h30);
        check(irqALine, 1'h1);
    endtask

    task automatic tClk();
        edges(8);
        wr(ADDR_CTRL1, 8'h10);
        edges(8);
        wr(ADDR_CTRL2, 8'h18);
        edges(0);
        rd(ADDR_CTRL2, 8'h18);
        wr(ADDR_CTRL1, 8'h00);
        edges(8);
        @(posedge clock);
        clockoutGatePin <= 1'h0;
        edges(0);
        @(posedge clock);
        clockoutGatePin <= 1'h1;
        wr(ADDR_CTRL2, 8'h10);
        edges(8);
    endtask

    task automatic tWeekly();
        wr(ADDR_ALW_MIN, 8'h15);
        wr(ADDR_ALW_HOUR, 8'h08);
        wr(ADDR_ALW_DAYS, 8'h08);
        wr(ADDR_CTRL1, 8'h80);
        st(3'h2, 6'h08, 7'h15);
        check(irqBLine, 1'h1);
        st(3'h3, 6'h08, 7'h15);
        check(irqBLine, 1'h0);
        check(irqALine, 1'h1);
        rd(ADDR_CTRL2, 8'h12);
        wr(ADDR_CTRL2, 8'h10);
        idle(2);
        check(irqBLine, 1'h1);
        st(3'h3, 6'h08, 7'h16);
        st(3'h3, 6'h08, 7'h15);
        check(irqBLine, 1'h0);
        @(posedge clock);
        poweronEvent <= 1'h1;
        @(posedge clock);
        poweronEvent <= 1'h0;
        idle(2);
        check(irqBLine, 1'h1);
        rd(ADDR_CTRL1, 8'h00);
        rd(ADDR_CTRL2, 8'h10);
    endtask

    task automatic tPeriodic();
        int n;
        wr(ADDR_CTRL1, 8'h02);
        pulseSec();
        check(irqALine, 1'h0);
        wr(ADDR_CTRL1, 8'h03);
        pulseSec();
        check(irqALine, 1'h0);
        waitA(1'h1, n);
        check(n > 32740 && n < 32780, 1'h1);
        @(posedge clock);
        adjustTicks <= 8'sh7F;
        adjustStrobe <= 1'h1;
        @(posedge clock);
        adjustStrobe <= 1'h0;
        waitA(1'h0, n);
        check(n > 32900 && n < 33016, 1'h1);
        wr(ADDR_CTRL1, 8'h04);
        n = 2;
        while (secondIncrement !== 1'h1 && n < 20) begin
            idle(1);
            n++;
        end
        check(n > 3 && n < 10, 1'h1);
        idle(3);
        check(irqALine, 1'h0);
        rd(ADDR_CTRL2, 8'h14);
        check(irqALine, 1'h0);
        wr(ADDR_CTRL2, 8'h10);
        idle(2);
        check(irqALine, 1'h1);
        wr(ADDR_CTRL1, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'h0;
        tRegs();
        tDaily();
        tClk();
        tWeekly();
        tPeriodic();
        results();
    end
endmodule
